//--- logic/edm_pkg.sv
// shared constants for the energy detect measurement block
package edm_pkg;

	// clock and time base
	localparam int CLK_PERIOD_NS = 20;            // core_clk period
	localparam int US_NS         = 1000;          // one microsecond in ns
	localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;
	localparam logic [5:0] US_DIV_MAX = 6'(CYC_PER_US - 1);

	// averaging time base choices, in microseconds
	localparam logic [7:0] TB0_US = 8'h02;        // 2 us
	localparam logic [7:0] TB1_US = 8'h08;        // 8 us
	localparam logic [7:0] TB2_US = 8'h20;        // 32 us
	localparam logic [7:0] TB3_US = 8'h80;        // 128 us

	// register address map, word index on the plain port
	localparam int ADDR_W = 2;
	localparam logic [ADDR_W-1:0] OFS_SIG_STRENGTH = 2'h0;
	localparam logic [ADDR_W-1:0] OFS_MODE_CONFIG  = 2'h1;
	localparam logic [ADDR_W-1:0] OFS_DURATION     = 2'h2;
	localparam logic [ADDR_W-1:0] OFS_ENERGY_VALUE = 2'h3;

	// duration register field layout
	localparam int DF_LSB  = 2;                   // duration factor 7:2
	localparam int DF_MSB  = 7;
	localparam int DTB_LSB = 0;                   // time base 1:0
	localparam int DTB_MSB = 1;

	// mode field encoding
	localparam logic [1:0] MODE_AUTO       = 2'h0;
	localparam logic [1:0] MODE_SINGLE     = 2'h1;
	localparam logic [1:0] MODE_CONTINUOUS = 2'h2;
	localparam logic [1:0] MODE_DISABLED   = 2'h3;

	// reset values
	localparam logic [5:0] DF_RST      = 6'h10;
	localparam logic [1:0] DTB_RST     = 2'h1;
	localparam logic [7:0] VALUE_INVAL = 8'h7F;   // invalid marker 127

	// measurement sequencer states
	typedef enum logic [1:0] {
		EDM_IDLE,
		EDM_MEASURE,
		EDM_DIVIDE
	} edm_state_t;

endpackage : edm_pkg

//--- logic/edm_energy_detect.sv
// Summary of operation
// R01 - measure only while receiver in receive state
// R02 - keep latest gain loop strength sample, 1dB
// R03 - result averages successive strength samples
// R04 - auto, single, continuous modes; auto after reset
// R05 - period length from duration register
// R06 - software picks duration above loop update time
// R07 - auto mode starts on baseband gain hold
// R08 - auto cancelled by baseband cancel or leaving receive
// R09 - baseband cancels on invalid frame or end
// R10 - auto result kept until next frame start
// R11 - cancelled auto measurement leaves invalid marker 127
// R12 - auto completion raises no completion pulse
// R13 - hold bit set starts auto measurement, no baseband
// R14 - hold bit cleared early stops, result invalid
// R15 - software disables baseband for manual modes
// R16 - writing 1 or 2 in receive starts measurement
// R17 - manual completion pulses interrupt, updates value
// R18 - single completion reverts mode to auto
// R19 - auto measurement may overwrite single result
// R20 - continuous repeats until mode 0 or receive left
// R21 - continuous overwrites unread results each period
// R22 - continuous stopped by receive exit sets auto
// R23 - mode codes auto 0, single 1, continuous 2, off 3
// R24 - time is factor times 2/8/32/128 us base
// R25 - value is signed 8 bit dBm
// R26 - value is rounded mean of period samples
// R27 - value register updated in one step
`timescale 1ns/1ps

module edm_energy_detect #(
	parameter int SUM_W = 24,                     // accumulator width
	parameter int CNT_W = 16                      // sample counter width
) (
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rst_n,
	// register port
	input  wire logic [edm_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [7:0]                reg_rdata,
	// receiver and baseband status
	input  wire logic                      rx_state,
	input  wire logic                      baseband_enable_bit,
	input  wire logic                      bb_gain_hold,
	input  wire logic                      bb_cancel,
	input  wire logic                      gain_hold_control_bit,
	// gain control loop samples
	input  wire logic                      rssi_valid,
	input  wire logic [7:0]                rssi_sample,
	// events and status
	output logic                           energy_complete_irq,
	output logic                           measure_busy,
	output logic      [1:0]                energy_mode_field
);

	// elaboration checks: sum must hold count times an 8 bit sample;
	// the six bit step counter caps the dividend at 62 bits, and the
	// count must cover every loop update of the longest period
	if (SUM_W < CNT_W + 8 || SUM_W > 62)
		$error("edm_energy_detect: SUM_W out of range");
	if (CNT_W < 12 || CNT_W > 30)
		$error("edm_energy_detect: CNT_W out of range");

	// whole state of the block in one record
	// one record keeps every flop under the same reset
	typedef struct packed {
		edm_pkg::edm_state_t  st;           // sequencer state
		logic [1:0]           mode;         // mode field
		logic [5:0]           df;           // duration factor
		logic [1:0]           dtb;          // duration time base
		logic [7:0]           value;        // energy value register
		logic [7:0]           rssi;         // signal strength register
		logic [7:0]           rdata;        // read data, one cycle late
		logic                 auto_run;     // period was auto triggered
		logic                 hold_q;       // hold bit, previous cycle
		logic                 irq;          // completion pulse
		logic [5:0]           us_div;       // cycles within a microsecond
		logic [13:0]          us_cnt;       // elapsed microseconds
		logic [13:0]          target;       // period length, microseconds
		logic [SUM_W-1:0]     sum;          // signed sample sum
		logic [CNT_W-1:0]     cnt;          // number of samples
		logic                 neg;          // mean is negative
		logic [SUM_W-1:0]     quo;          // divider quotient/dividend
		logic [CNT_W:0]       rem;          // divider remainder
		logic [5:0]           step;         // divider steps left
	} edm_regs_t;

	edm_regs_t s_q;                             // registered state
	edm_regs_t s_d;                             // next state

	// time base lookup, in microseconds
	function automatic logic [7:0] tb_us(input logic [1:0] sel);
		logic [7:0] r;
		r = edm_pkg::TB0_US;
		case (sel)
			2'h0:    r = edm_pkg::TB0_US;
			2'h1:    r = edm_pkg::TB1_US;
			2'h2:    r = edm_pkg::TB2_US;
			default: r = edm_pkg::TB3_US;
		endcase
		return r;
	endfunction : tb_us

	// open a fresh averaging period
	function automatic edm_regs_t start_period(input edm_regs_t x,
			input logic is_auto);
		edm_regs_t r;
		r          = x;
		r.st       = edm_pkg::EDM_MEASURE;
		r.auto_run = is_auto;
		r.us_div   = 6'h00;
		r.us_cnt   = 14'h0000;
		// R24 factor times base; both widened first, or 63 x 128
		// would wrap in an eight bit product
		r.target   = 14'(x.df) * 14'(tb_us(x.dtb));
		r.sum      = '0;
		r.cnt      = '0;
		return r;
	endfunction : start_period

	// next state logic
	always_comb
	begin
		logic             tick;             // one microsecond elapsed
		logic             hold_rise;        // hold bit just set
		logic             auto_abort;       // auto period cancelled
		logic [SUM_W-1:0] mag;              // magnitude of the sum
		logic [CNT_W:0]   rem_sh;           // shifted remainder
		tick       = 1'b0;
		hold_rise  = 1'b0;
		auto_abort = 1'b0;
		mag        = '0;
		rem_sh     = '0;
		s_d        = s_q;
		s_d.irq    = 1'b0;
		s_d.rdata  = 8'h00;
		s_d.hold_q = gain_hold_control_bit;
		// hold_q tracks the bit even outside receive, so a bit that is
		// already high on entry does not count as a fresh start
		hold_rise  = gain_hold_control_bit & ~s_q.hold_q;

		// R02 latest loop sample is visible to software
		if (rssi_valid)
			s_d.rssi = rssi_sample;

		case (s_q.st)
			edm_pkg::EDM_IDLE:
			begin
				// R07 baseband hold opens an auto period
				// R19 this may overwrite a stored single result
				// R10 frame start leaves the stored value alone
				if (rx_state && s_q.mode == edm_pkg::MODE_AUTO &&
						baseband_enable_bit && bb_gain_hold)
					s_d = start_period(s_d, 1'b1);
				// R13 hold bit set with baseband off
				else if (rx_state && s_q.mode == edm_pkg::MODE_AUTO &&
						!baseband_enable_bit && hold_rise)
					s_d = start_period(s_d, 1'b1);
			end

			edm_pkg::EDM_MEASURE:
			begin
				// R08 baseband cancel ends the auto period
				// R09 the baseband cancels on a bad frame or its end
				if (s_q.auto_run && baseband_enable_bit && bb_cancel)
					auto_abort = 1'b1;
				// R14 hold released early, no baseband
				if (s_q.auto_run && !baseband_enable_bit &&
						!gain_hold_control_bit)
					auto_abort = 1'b1;
				// R01 nothing runs outside receive state
				// leaving receive outranks a cancel in the same cycle
				if (!rx_state)
				begin
					s_d.st = edm_pkg::EDM_IDLE;
					// R11 cancelled auto period leaves marker
					if (s_q.auto_run)
						s_d.value = edm_pkg::VALUE_INVAL;
					// R22 manual modes fall back to auto
					else
						s_d.mode = edm_pkg::MODE_AUTO;
				end
				else if (auto_abort)
				begin
					// R11 invalid marker after cancel
					s_d.st    = edm_pkg::EDM_IDLE;
					s_d.value = edm_pkg::VALUE_INVAL;
				end
				else
				begin
					// R03 accumulate valid samples; 127 means no estimate
					if (rssi_valid && rssi_sample != edm_pkg::VALUE_INVAL)
					begin
						s_d.sum = s_q.sum +
							{{(SUM_W-8){rssi_sample[7]}}, rssi_sample};
						s_d.cnt = s_q.cnt + 1'b1;
					end
					// microsecond divider, runs only inside a period
					// so each period starts on a whole microsecond
					if (s_q.us_div == edm_pkg::US_DIV_MAX)
					begin
						s_d.us_div = 6'h00;
						tick       = 1'b1;
					end
					else
						s_d.us_div = s_q.us_div + 6'h01;
					// R05 period ends when duration has elapsed
					if (tick)
					begin
						s_d.us_cnt = s_q.us_cnt + 14'h0001;
						if (s_q.us_cnt + 14'h0001 >= s_q.target)
							s_d.st = edm_pkg::EDM_DIVIDE;
					end
					// divider setup, sign is stripped then reapplied
					if (s_d.st == edm_pkg::EDM_DIVIDE)
					begin
						mag       = s_d.sum[SUM_W-1] ? ('0 - s_d.sum) :
							s_d.sum;
						s_d.neg   = s_d.sum[SUM_W-1];
						// R26 adding half the count rounds the mean
						s_d.quo   = mag + SUM_W'(s_d.cnt >> 1);
						s_d.rem   = '0;
						s_d.step  = 6'(SUM_W);
					end
				end
			end

			edm_pkg::EDM_DIVIDE:
			begin
				// R01 leaving receive also ends the division;
				// a half finished mean is never published
				if (!rx_state)
				begin
					s_d.st = edm_pkg::EDM_IDLE;
					// R08 auto result cancelled, marker left
					if (s_q.auto_run)
						s_d.value = edm_pkg::VALUE_INVAL;
					// R22 manual modes fall back to auto
					else
						s_d.mode = edm_pkg::MODE_AUTO;
				end
				// restoring division, one quotient bit per cycle;
				// slow but far smaller than a parallel divider
				else if (s_q.step != 6'h00)
				begin
					rem_sh    = {s_q.rem[CNT_W-1:0], s_q.quo[SUM_W-1]};
					s_d.quo   = {s_q.quo[SUM_W-2:0], 1'b0};
					if (rem_sh >= {1'b0, s_q.cnt} && s_q.cnt != '0)
					begin
						rem_sh     = rem_sh - {1'b0, s_q.cnt};
						s_d.quo[0] = 1'b1;
					end
					s_d.rem   = rem_sh;
					s_d.step  = s_q.step - 6'h01;
				end
				else
				begin
					s_d.st = edm_pkg::EDM_IDLE;
					// R27 value written whole, in this one cycle
					if (s_q.cnt == '0)
						s_d.value = edm_pkg::VALUE_INVAL;
					// R25 signed two's complement result
					else if (s_q.neg)
						s_d.value = 8'h00 - s_q.quo[7:0];
					else
						s_d.value = s_q.quo[7:0];
					// R12 auto completion stays silent
					if (!s_q.auto_run)
					begin
						// R17 manual completion pulses the interrupt
						s_d.irq = 1'b1;
						// R18 single measurement returns to auto
						if (s_q.mode == edm_pkg::MODE_SINGLE)
							s_d.mode = edm_pkg::MODE_AUTO;
						// R20 continuous keeps going in receive
						else if (s_q.mode == edm_pkg::MODE_CONTINUOUS &&
								rx_state)
							// R21 next result overwrites this one
							s_d = start_period(s_d, 1'b0);
						// R22 receive left: back to auto
						else if (s_q.mode == edm_pkg::MODE_CONTINUOUS)
							s_d.mode = edm_pkg::MODE_AUTO;
					end
				end
			end

			default:
				s_d.st = edm_pkg::EDM_IDLE;
		endcase

		// register writes come last so software wins over sequencer
		if (reg_wr)
		begin
			case (reg_addr)
				edm_pkg::OFS_MODE_CONFIG:
				begin
					// R23 mode field takes the low two bits
					s_d.mode = reg_wdata[1:0];
					// R16 single or continuous start in receive
					if (rx_state && (reg_wdata[1:0] ==
							edm_pkg::MODE_SINGLE ||
							reg_wdata[1:0] == edm_pkg::MODE_CONTINUOUS))
						s_d = start_period(s_d, 1'b0);
					// R20 writing auto or off stops a manual run
					else if (s_q.st != edm_pkg::EDM_IDLE && !s_q.auto_run)
						s_d.st = edm_pkg::EDM_IDLE;
					// R23 disabled mode stops any run
					else if (reg_wdata[1:0] == edm_pkg::MODE_DISABLED)
						s_d.st = edm_pkg::EDM_IDLE;
				end
				edm_pkg::OFS_DURATION:
				begin
					// takes effect at the next period start
					s_d.df  = reg_wdata[edm_pkg::DF_MSB:edm_pkg::DF_LSB];
					s_d.dtb = reg_wdata[edm_pkg::DTB_MSB:edm_pkg::DTB_LSB];
				end
				// status registers ignore writes
				default:
					s_d.mode = s_d.mode;
			endcase
		end

		// read data stands in the cycle after the strobe
		// reads have no side effects, so polling is safe
		if (reg_rd)
		begin
			case (reg_addr)
				edm_pkg::OFS_SIG_STRENGTH:
					s_d.rdata = s_q.rssi;
				edm_pkg::OFS_MODE_CONFIG:
					s_d.rdata = {6'h00, s_q.mode};
				edm_pkg::OFS_DURATION:
					s_d.rdata = {s_q.df, s_q.dtb};
				// R10 value holds until overwritten
				default:
					s_d.rdata = s_q.value;
			endcase
		end
	end

	// state register; reset gives auto mode and an invalid value
	// the reset branch loads constants only
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q          <= '0;
			s_q.st       <= edm_pkg::EDM_IDLE;
			// R04 auto mode after reset
			s_q.mode     <= edm_pkg::MODE_AUTO;
			s_q.df       <= edm_pkg::DF_RST;
			s_q.dtb      <= edm_pkg::DTB_RST;
			s_q.value    <= edm_pkg::VALUE_INVAL;
			s_q.rssi     <= edm_pkg::VALUE_INVAL;
		end
		else
			s_q <= s_d;
	end

	// outputs, all but busy straight from the state register
	// busy is a decode of the state, one gate after the flops
	assign reg_rdata           = s_q.rdata;
	assign energy_complete_irq = s_q.irq;
	assign measure_busy        = (s_q.st != edm_pkg::EDM_IDLE);
	assign energy_mode_field   = s_q.mode;

endmodule : edm_energy_detect

//--- sim/edm_energy_detect_checker.sv
`timescale 1ns/1ps
module edm_energy_detect_checker (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst_n,
	// register writes
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	// receiver and status
	input wire logic       rx_state,
	input wire logic       energy_complete_irq,
	input wire logic       measure_busy,
	input wire logic [1:0] energy_mode_field
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	// software start of a single run
	sequence s_go;
		rx_state && reg_wr && reg_addr == 2'h1 && reg_wdata[1:0] == 2'h1;
	endsequence
	// shortest run is one microsecond, so busy must hold a while
	sequence s_run;
		measure_busy [*8];
	endsequence

	period_min_a: assert property (
		s_go |=> s_run)
		else $error("single run too short");
	no_rx_idle_a: assert property (
		(!rx_state) [*3] |-> !measure_busy)
		else $error("busy outside receive");
	irq_pulse_a: assert property (
		energy_complete_irq |=> !energy_complete_irq)
		else $error("completion pulse too long");
	auto_silent_a: assert property (
		energy_complete_irq |-> $past(energy_mode_field) != 2'h0)
		else $error("completion pulse in auto mode");
	single_end_a: assert property (
		energy_complete_irq |-> energy_mode_field != 2'h1)
		else $error("mode still single at completion");
	cont_again_a: assert property (
		energy_complete_irq && energy_mode_field == 2'h2 && rx_state
		|-> ##[0:2] measure_busy)
		else $error("continuous run did not restart");
	cont_exit_a: assert property (
		$fell(rx_state) && energy_mode_field == 2'h2
		|-> ##[1:3] energy_mode_field == 2'h0)
		else $error("mode not back to auto");
	off_idle_a: assert property (
		energy_mode_field == 2'h3 && !measure_busy && !reg_wr
		|=> !measure_busy)
		else $error("run started while disabled");
endmodule : edm_energy_detect_checker

bind edm_energy_detect edm_energy_detect_checker
	i_edm_energy_detect_checker (
	.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .rx_state,
	.energy_complete_irq, .measure_busy, .energy_mode_field
);

//--- sim/edm_far_model.sv
`timescale 1ns/1ps
module edm_far_model (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// bench controls
	input  wire logic [7:0] level,
	input  wire logic [1:0] cmd,
	// gain loop and baseband
	output logic            rssi_valid,
	output logic      [7:0] rssi_sample,
	output logic            bb_gain_hold,
	output logic            bb_cancel
);
	logic [3:0] tick_q;                           // sample pacing

	// sample every 10 cycles
	// pacing well below the shortest period; bus is junk between samples
	// frame hold and cancel
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			tick_q <= 4'h0;
			rssi_valid <= 1'b0;
			rssi_sample <= 8'h7F;
			bb_gain_hold <= 1'b0;
			bb_cancel <= 1'b0;
		end
		else
		begin
			tick_q <= (tick_q == 4'h9) ? 4'h0 : tick_q + 4'h1;
			rssi_valid <= (tick_q == 4'h9);
			rssi_sample <= (tick_q == 4'h9) ? level : ~rssi_sample;
			bb_gain_hold <= (cmd == 2'h1);
			bb_cancel <= (cmd == 2'h2);
		end
endmodule : edm_far_model

//--- sim/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin failures++; \
	$display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
	// clock, reset, register port
	logic       core_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	// receiver and far side controls
	logic       rx_state = 1'b0;
	logic       baseband_enable_bit = 1'b0;
	logic       gain_hold_control_bit = 1'b0;
	logic [7:0] level = 8'h00;
	logic [1:0] cmd = 2'h0;
	logic       rssi_valid, bb_gain_hold, bb_cancel;
	logic [7:0] rssi_sample;
	// outputs and bench state
	logic       energy_complete_irq, measure_busy;
	logic [1:0] energy_mode_field;
	logic [7:0] exp_q[$];                         // pending read results
	logic [7:0] ev;
	logic       rd_q = 1'b0;
	int         failures = 0;
	int         tests_run = 0;
	int         bt[4] = '{2, 8, 32, 128};         // time base in us

	initial
		forever #10 core_clk = ~core_clk;

	edm_energy_detect i_edm_energy_detect (.core_clk, .rst_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_state,
		.baseband_enable_bit, .bb_gain_hold, .bb_cancel,
		.gain_hold_control_bit, .rssi_valid, .rssi_sample,
		.energy_complete_irq, .measure_busy, .energy_mode_field);
	edm_far_model i_edm_far_model (.core_clk, .rst_n, .level, .cmd,
		.rssi_valid, .rssi_sample, .bb_gain_hold, .bb_cancel);

	// read data checked one cycle after its strobe
	always @(posedge core_clk)
		rd_q <= reg_rd;
	always @(negedge core_clk)
		if (rd_q)
		begin
			ev = exp_q.pop_front();
			`CHK("rdata", ev, reg_rdata)
		end

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask : rd

	// one cycle request to the baseband model
	task automatic frame(input logic [1:0] c);
		@(posedge core_clk) cmd <= c;
		@(posedge core_clk) cmd <= 2'h0;
	endtask : frame

	// bounded wait for completion pulse or idle
	task automatic wt(input bit irq, output int n);
		n = 0;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while ((irq ? energy_complete_irq : !measure_busy) !== 1'b1
			&& n < 30000);
		if (n >= 30000)
		begin
			failures++;
			test_done();
		end
	endtask : wt

	task automatic test_done;
		if (failures == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	// main sequence
	initial
	begin
		int n;
		logic [7:0] s;
		n = $urandom(39134);
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(2'h0, 8'h7F);
		rd(2'h1, 8'h00);
		rd(2'h2, 8'h41);
		wr(2'h3, 8'h00);
		rd(2'h3, 8'h7F);
		wr(2'h1, 8'hFF);
		rd(2'h1, 8'h03);
		@(posedge core_clk) rx_state <= 1'b1;
		@(posedge core_clk) gain_hold_control_bit <= 1'b1;
		repeat (5) @(negedge core_clk);
		`CHK("busy", 1'b0, measure_busy)
		@(posedge core_clk) gain_hold_control_bit <= 1'b0;
		@(posedge core_clk) rx_state <= 1'b0;
		wr(2'h1, 8'h01);
		repeat (3) @(negedge core_clk);
		`CHK("busy", 1'b0, measure_busy)
		wr(2'h1, 8'h00);
		@(posedge core_clk) rx_state <= 1'b1;
		// baseband kept off for the manual runs
		// single runs over every time base, factor t+1
		for (int t = 0; t < 4; t++)
		begin
			s = 8'($urandom_range(131) - 127);
			@(posedge core_clk) level <= s;
			wr(2'h2, {6'(t + 1), 2'(t)});
			wr(2'h1, 8'h01);
			wt(1'b1, n);
			n = n - (t + 1) * bt[t] * 50;
			`CHK("period", 1'b1, n > 22 && n < 30)
			`CHK("mode", 2'h0, energy_mode_field)
			rd(2'h3, s);
		end
		// continuous overwrites, then stop by mode 0
		wr(2'h2, 8'h04);
		wr(2'h1, 8'h02);
		wt(1'b1, n);
		s = 8'($urandom_range(131) - 127);
		@(posedge core_clk) level <= s;
		repeat (2) wt(1'b1, n);
		`CHK("mode", 2'h2, energy_mode_field)
		rd(2'h3, s);
		wr(2'h1, 8'h00);
		repeat (3) @(negedge core_clk);
		`CHK("busy", 1'b0, measure_busy)
		wr(2'h1, 8'h02);
		wt(1'b1, n);
		@(posedge core_clk) rx_state <= 1'b0;
		repeat (3) @(negedge core_clk);
		`CHK("mode", 2'h0, energy_mode_field)
		// frame triggered run, then a cancelled frame
		// the frame run overwrites the last manual result
		s = 8'($urandom_range(131) - 127);
		@(posedge core_clk) level <= s;
		baseband_enable_bit <= 1'b1;
		rx_state <= 1'b1;
		frame(2'h1);
		repeat (3) @(negedge core_clk);
		wt(1'b0, n);
		rd(2'h3, s);
		frame(2'h1);
		repeat (20) @(posedge core_clk);
		frame(2'h2);
		repeat (3) @(negedge core_clk);
		rd(2'h3, 8'h7F);
		// hold bit run without baseband, then early release
		s = 8'($urandom_range(131) - 127);
		@(posedge core_clk) level <= s;
		baseband_enable_bit <= 1'b0;
		gain_hold_control_bit <= 1'b1;
		repeat (3) @(negedge core_clk);
		wt(1'b0, n);
		rd(2'h3, s);
		@(posedge core_clk) gain_hold_control_bit <= 1'b0;
		@(posedge core_clk) gain_hold_control_bit <= 1'b1;
		repeat (20) @(posedge core_clk);
		gain_hold_control_bit <= 1'b0;
		repeat (3) @(negedge core_clk);
		rd(2'h3, 8'h7F);
		test_done();
	end

	// watchdog well beyond the longest expected run
	initial
	begin
		#1_500_000;
		failures++;
		test_done();
	end
endmodule : tb
